// ==== rtl/eeprom_engine_pkg.sv ====
package eeprom_engine_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int MAIN_BYTES = 8192;
    localparam int PAGE_W = 5;
    localparam int ID_BYTES = 32;
    localparam int SERIAL_W = 4;
    localparam int BYTE_W = 8;

    // ------------------------------------------------------------
    // Device address word fields
    // ------------------------------------------------------------
    localparam logic [2:0] DEV_CODE_TOP = 3'h5;
    localparam int DEV_CODE_MSB = 7;
    localparam int DEV_CODE_LSB = 5;
    localparam int DEV_AREA_BIT = 4;
    localparam int DEV_STRAP_MSB = 3;
    localparam int DEV_STRAP_LSB = 1;
    localparam int DEV_RW_BIT = 0;

    // ------------------------------------------------------------
    // Word address fields and codes for the extra areas
    // ------------------------------------------------------------
    localparam int WA_SEL_MSB = 11;
    localparam int WA_SEL_LSB = 10;
    localparam int WA_LOCK_BIT = 10;
    localparam logic [1:0] SEL_ID_PAGE = 2'h0;
    localparam logic [1:0] SEL_SERIAL = 2'h2;
    localparam int LOCK_DATA_BIT = 1;
    localparam logic [7:0] UNDEF_BYTE = 8'hFF;

    // ------------------------------------------------------------
    // Bit counting within a byte and its acknowledge slot
    // ------------------------------------------------------------
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 100_000_000;
    localparam longint WRITE_CYCLE_MS = 5;
    localparam longint WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * CLK_HZ / 1000;
    localparam int BUSY_W = 24;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WA_HI,
        ST_WA_LO,
        ST_WDATA,
        ST_READ,
        ST_IGNORE
    } link_state_t;

endpackage

// ==== rtl/eeprom_engine.sv ====
`timescale 1ns/1ns

module eeprom_engine #(
    parameter longint WRITE_CYCLES = eeprom_engine_pkg::WRITE_CYCLE_CYCLES,
    parameter logic [127:0] SERIAL_NUMBER = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic strap_select_bit0_i,
    input wire logic strap_select_bit1_i,
    input wire logic strap_select_bit2_i,
    input wire logic write_inhibit_pin_i,
    output logic standby_o,
    output logic write_busy_o
);
    import eeprom_engine_pkg::*;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (64'h1 << BUSY_W)) begin : g_chk
        $error("WRITE_CYCLES out of range for the busy counter");
    end
    // The array and page sizes follow from the address fields; a larger
    // size would leave bytes that no address can reach, a smaller one addresses with no byte behind them.
    if (MAIN_BYTES != (1 << ADDR_W)) begin : g_chk_array
        $error("MAIN_BYTES must equal two to the power ADDR_W");
    end
    if (ID_BYTES != (1 << PAGE_W)) begin : g_chk_page
        $error("ID_BYTES must equal two to the power PAGE_W");
    end

    // ------------------------------------------------------------
    // Link clock domain
    // ------------------------------------------------------------
    // Only the captured data bit lives here; it stays stable from the
    // rising edge until the next one, well past the falling edge that
    // the core uses to consume it.
    logic link_bit;

    always_ff @(posedge scl_i) begin
        link_bit <= sda_i;
    end

    // ------------------------------------------------------------
    // Synchronisers into the core clock
    // ------------------------------------------------------------
    // Clock and data pass the same depth, so a start or stop keeps the
    // order of its edges; the extra stages cost only latency.
    logic [1:0] scl_meta, scl_sync;
    logic [1:0] sda_meta, sda_sync;
    logic bit_meta, bit_sync;
    logic [3:0] pin_meta, pin_sync;

    always_ff @(posedge mclk_i) begin
        scl_meta <= {scl_meta[0], scl_i};
        sda_meta <= {sda_meta[0], sda_i};
        bit_meta <= link_bit;
        pin_meta <= {write_inhibit_pin_i, strap_select_bit2_i,
                     strap_select_bit1_i, strap_select_bit0_i};
    end

    always_ff @(posedge mclk_i) begin
        scl_sync <= {scl_sync[0], scl_meta[1]};
        sda_sync <= {sda_sync[0], sda_meta[1]};
        bit_sync <= bit_meta;
        pin_sync <= pin_meta;
    end

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    // Start and stop need the clock seen high twice, so a data change
    // close to a clock edge cannot fake one.
    wire scl_fall = scl_sync[1] & ~scl_sync[0];
    wire scl_high = scl_sync[1] & scl_sync[0];
    wire start_ev = scl_high & sda_sync[1] & ~sda_sync[0];
    wire stop_ev = scl_high & ~sda_sync[1] & sda_sync[0];
    wire [2:0] straps = pin_sync[2:0];
    wire inhibit = pin_sync[3];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    link_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_sr;
    logic [7:0] tx_sr;
    logic [ADDR_W-1:0] addr;
    logic [4:0] addr_hi;
    logic id_area;
    logic id_locked;
    logic write_pending;
    logic lead_fall;
    logic last_was_read;
    logic [BUSY_W-1:0] busy_cnt;
    logic [7:0] main_mem [MAIN_BYTES];
    logic [7:0] id_mem [ID_BYTES];

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] page_step(
        input logic [ADDR_W-1:0] a
    );
        page_step = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 5'h01};
    endfunction

    wire [7:0] rx_byte = {rx_sr[6:0], bit_sync};
    wire byte_done = scl_fall & (bit_cnt == BIT_LAST);
    wire ack_slot = scl_fall & (bit_cnt == BIT_ACK);
    wire busy = (busy_cnt != '0);
    wire dev_match = (rx_byte[DEV_CODE_MSB:DEV_CODE_LSB] == DEV_CODE_TOP)
        && (rx_byte[DEV_STRAP_MSB:DEV_STRAP_LSB] == straps);
    wire dev_ack = dev_match & ~busy;
    wire dev_read = rx_byte[DEV_RW_BIT];
    wire dev_id = rx_byte[DEV_AREA_BIT];
    wire [1:0] sel = addr[WA_SEL_MSB:WA_SEL_LSB];
    wire [7:0] serial_byte =
        SERIAL_NUMBER[(15 - addr[SERIAL_W-1:0]) * BYTE_W +: BYTE_W];
    wire [7:0] extra_byte = (sel == SEL_ID_PAGE) ? id_mem[addr[PAGE_W-1:0]]
        : (sel == SEL_SERIAL) ? serial_byte : UNDEF_BYTE;
    wire [7:0] rd_byte = id_area ? extra_byte : main_mem[addr];
    wire is_lock_cmd = id_area & addr[WA_LOCK_BIT];
    wire id_write_ok = id_area & (sel == SEL_ID_PAGE) & ~id_locked;
    wire data_ack = ~id_area | is_lock_cmd | id_write_ok;
    wire master_ack = ~bit_sync;

    // ------------------------------------------------------------
    // Write enables
    // ------------------------------------------------------------
    // An inhibited write is still acknowledged; the controller learns of
    // it only by reading back, and no write cycle starts.
    wire data_in = byte_done & (state == ST_WDATA) & ~inhibit;
    wire main_we = data_in & ~id_area;
    wire id_we = data_in & ~is_lock_cmd & id_write_ok;
    wire lock_set = data_in & is_lock_cmd
        & rx_byte[LOCK_DATA_BIT];

    // ------------------------------------------------------------
    // Read shifter
    // ------------------------------------------------------------
    // Each bit goes out on the fall that ends the one before, so it has
    // the whole low phase to settle before the controller samples it.
    wire tx_shift = (bit_cnt < BIT_LAST);
    wire tx_release = (bit_cnt == BIT_LAST);
    wire [7:0] tx_next = {tx_sr[6:0], 1'b0};
    wire first_oe = ~rd_byte[7];

    // ------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------
    // Writes land at once rather than at the stop; the timed cycle that
    // follows only models the busy window seen on the bus.
    always_ff @(posedge mclk_i) begin
        if (main_we) begin
            main_mem[addr] <= rx_byte;
        end
        if (id_we) begin
            id_mem[addr[PAGE_W-1:0]] <= rx_byte;
        end
    end

    // ------------------------------------------------------------
    // Protocol sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
            bit_cnt <= '0;
            rx_sr <= '0;
            tx_sr <= '0;
            sda_oe_o <= 1'b0;
            id_area <= 1'b0;
            addr_hi <= '0;
            last_was_read <= 1'b0;
            lead_fall <= 1'b0;
        end else if (start_ev) begin
            state <= ST_DEV;
            bit_cnt <= '0;
            sda_oe_o <= 1'b0;
            lead_fall <= 1'b1;
        end else if (stop_ev) begin
            state <= ST_IDLE;
            bit_cnt <= '0;
            sda_oe_o <= 1'b0;
            lead_fall <= 1'b0;
        end else if (scl_fall && lead_fall) begin
            // The start's own clock fall ends no bit
            lead_fall <= 1'b0;
        end else if (scl_fall && state != ST_IDLE && state != ST_IGNORE) begin
            rx_sr <= rx_byte;
            bit_cnt <= (bit_cnt == BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
            if (state == ST_READ) begin
                if (tx_shift) begin
                    tx_sr <= tx_next;
                    sda_oe_o <= ~tx_sr[6];
                end else if (tx_release) begin
                    sda_oe_o <= 1'b0;
                end else if (master_ack) begin
                    tx_sr <= rd_byte;
                    sda_oe_o <= first_oe;
                end else begin
                    state <= ST_IGNORE;
                end
            end else if (byte_done) begin
                unique case (state)
                    ST_DEV: begin
                        sda_oe_o <= dev_ack;
                        id_area <= dev_id;
                        last_was_read <= dev_read;
                        // A mismatch drops straight back to standby
                        if (!dev_ack) begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_WA_HI: begin
                        sda_oe_o <= 1'b1;
                        addr_hi <= rx_byte[4:0];
                    end
                    ST_WA_LO: begin
                        sda_oe_o <= 1'b1;
                    end
                    ST_WDATA: begin
                        sda_oe_o <= data_ack;
                        if (!data_ack) begin
                            state <= ST_IGNORE;
                        end
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end else if (ack_slot) begin
                sda_oe_o <= 1'b0;
                unique case (state)
                    ST_DEV: begin
                        if (last_was_read) begin
                            state <= ST_READ;
                            tx_sr <= rd_byte;
                            sda_oe_o <= first_oe;
                        end else begin
                            state <= ST_WA_HI;
                        end
                    end
                    ST_WA_HI: state <= ST_WA_LO;
                    ST_WA_LO: state <= ST_WDATA;
                    default: state <= state;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Address counter
    // ------------------------------------------------------------
    // Reads step the whole counter so they run across pages; writes
    // step only the page offset.
    wire read_load = ack_slot & (((state == ST_DEV) & last_was_read)
        | ((state == ST_READ) & master_ack));

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            addr <= '0;
        end else if (byte_done && state == ST_WA_LO) begin
            addr <= {addr_hi, rx_byte};
        end else if (byte_done && state == ST_WDATA) begin
            addr <= page_step(addr);
        end else if (read_load) begin
            addr <= addr + 13'h0001;
        end
    end

    // ------------------------------------------------------------
    // Lock bit and self-timed write cycle
    // ------------------------------------------------------------
    // The lock bit models a nonvolatile fuse: only a device reset
    // clears it, standing in for a fresh part.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            id_locked <= 1'b0;
            write_pending <= 1'b0;
            busy_cnt <= '0;
        end else begin
            if (lock_set) begin
                id_locked <= 1'b1;
            end
            // A repeated start drops the pending flag, so the dummy write
            // of a random read starts no write cycle.
            if (start_ev) begin
                write_pending <= 1'b0;
            end else if (main_we || id_we || lock_set) begin
                write_pending <= 1'b1;
            end
            if (stop_ev && write_pending) begin
                busy_cnt <= BUSY_W'(WRITE_CYCLES);
                write_pending <= 1'b0;
            end else if (busy) begin
                busy_cnt <= busy_cnt - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // The pin is open drain: only its enable moves, the level stays low.
    // Standby stays low through any write cycle and any transfer addressed to this device; a mismatch returns it high.
    assign sda_o = 1'b0;
    assign write_busy_o = busy;
    assign standby_o = (state == ST_IDLE) & ~busy;

endmodule

// ==== testbench/i2c_ctrl_model.sv ====
`timescale 1ns/1ns

// ------------------------------------------------------------
// Two-wire controller: clock stands high between frames
// ------------------------------------------------------------
module i2c_ctrl_model (
    output logic scl_o,
    output logic sda_drv_o,
    input wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_drv_o = 1'b1;
    end

    // Start, or repeated start when the clock is low
    task automatic start();
        if (!scl_o) begin
            #24 sda_drv_o = 1'b1;
            #24 scl_o = 1'b1;
        end
        #200 sda_drv_o = 1'b0;
        #200 scl_o = 1'b0;
    endtask

    task automatic stop();
        #24 sda_drv_o = 1'b0;
        #24 scl_o = 1'b1;
        #200 sda_drv_o = 1'b1;
        #400;
    endtask

    // Nine bits, 64 ns each; data moves mid-low so it never fakes a start
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #24 sda_drv_o = tx[i];
            #24 scl_o = 1'b1;
            rx[i] = sda_i;
            #16 scl_o = 1'b0;
        end
    endtask
endmodule

// ==== testbench/eeprom_engine_assertions.sv ====
`timescale 1ns/1ns

module eeprom_engine_assertions #(
    parameter longint WRITE_CYCLES = 50
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic standby_o,
    input wire logic write_busy_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    // ------------------------------------------------------------
    // Stop detection and write cycle length
    // ------------------------------------------------------------
    logic [1:0] q1, q2, q3;
    int busy_cnt;
    wire bus_stop = q2 == 2'b11 && q3 == 2'b10;
    always_ff @(posedge mclk_i) begin
        q1 <= {scl_i, sda_i};
        q2 <= q1;
        q3 <= q2;
        busy_cnt <= write_busy_o ? busy_cnt + 1 : 0;
    end

    drive_low_a: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("data drive not low");
    oe_clock_low_a: assert property ($changed(sda_oe_o) |->
        !$past(scl_i))
        else $error("data output moved while clock high");
    busy_len_a: assert property ($fell(write_busy_o) |->
        busy_cnt == WRITE_CYCLES)
        else $error("write cycle length wrong");
    busy_quiet_a: assert property (write_busy_o |-> !sda_oe_o)
        else $error("bus answered during write cycle");
    busy_standby_a: assert property (write_busy_o |-> !standby_o)
        else $error("standby during write cycle");
    done_standby_a: assert property ($fell(write_busy_o) |->
        ##[0:2] standby_o)
        else $error("no standby after write cycle");
    stop_idle_a: assert property (bus_stop |->
        ##[1:8] (standby_o || write_busy_o))
        else $error("not idle after stop");
    standby_quiet_a: assert property (standby_o |-> !sda_oe_o)
        else $error("driving data while in standby");

    cover property ($rose(write_busy_o));
    cover property ($rose(sda_oe_o));
    cover property (bus_stop ##2 standby_o);
endmodule

bind eeprom_engine eeprom_engine_assertions #(
    .WRITE_CYCLES(WRITE_CYCLES)
) u_eeprom_engine_assertions (
    .mclk_i(mclk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .standby_o(standby_o),
    .write_busy_o(write_busy_o)
);

// ==== testbench/test_eeprom_engine.sv ====
`timescale 1ns/1ns

module test_eeprom_engine;
    import eeprom_engine_pkg::*;
    localparam logic [127:0] SN = 128'h9E37_1C4D_2B6A_5F08_7311_C0DE_4A2B_1D3E;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [2:0] straps = 3'h5;
    logic wp = 1'b0;
    wire scl, drv, sda, so, oe, sb, busy;
    int err_total = 0;
    int compares = 0;
    // Pull-up: released wire reads high
    assign sda = drv & ~oe;

    eeprom_engine #(.WRITE_CYCLES(400), .SERIAL_NUMBER(SN)) u_eeprom_engine (
        .mclk_i(mclk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
        .sda_o(so), .sda_oe_o(oe), .strap_select_bit0_i(straps[0]),
        .strap_select_bit1_i(straps[1]), .strap_select_bit2_i(straps[2]),
        .write_inhibit_pin_i(wp), .standby_o(sb), .write_busy_o(busy));
    i2c_ctrl_model u_i2c_ctrl_model (.scl_o(scl), .sda_drv_o(drv),
        .sda_i(sda));

    initial forever #5 mclk_i = ~mclk_i;

    // ------------------------------------------------------------
    // Shared bus steps and comparison
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tx(input logic [7:0] b, input logic exp);
        logic [8:0] r;
        u_i2c_ctrl_model.xfer({b, 1'b1}, r);
        check("ack", {7'h0, ~r[0]}, {7'h0, exp});
        check("sda drive", {7'h0, so}, 8'h00);
    endtask
    task automatic rx(input logic [7:0] exp, input logic last);
        logic [8:0] r;
        u_i2c_ctrl_model.xfer({8'hFF, last}, r);
        check("data", r[8:1], exp);
    endtask
    task automatic dev(input logic area, input logic rd, input logic exp);
        u_i2c_ctrl_model.start();
        tx({3'h5, area, 3'h5, rd}, exp);
    endtask
    task automatic addr(input logic area, input logic [7:0] hi, lo);
        dev(area, 1'b0, 1'b1);
        tx(hi, 1'b1);
        tx(lo, 1'b1);
    endtask
    task automatic wait_idle();
        repeat (2) @(negedge mclk_i);
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge mclk_i);
        check("standby", {7'h0, sb}, 8'h01);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_write_poll();
        addr(1'b0, 8'h00, 8'h00);
        tx(8'hC3, 1'b1);
        u_i2c_ctrl_model.stop();
        dev(1'b0, 1'b0, 1'b0);
        u_i2c_ctrl_model.stop();
        wait_idle();
        dev(1'b0, 1'b0, 1'b1);
        u_i2c_ctrl_model.stop();
    endtask
    task automatic t_page_read();
        addr(1'b0, 8'h1F, 8'hFE);
        tx(8'h11, 1'b1);
        tx(8'h22, 1'b1);
        tx(8'h33, 1'b1);
        u_i2c_ctrl_model.stop();
        wait_idle();
        addr(1'b0, 8'h1F, 8'hE0);
        dev(1'b0, 1'b1, 1'b1);
        rx(8'h33, 1'b1);
        u_i2c_ctrl_model.stop();
        wait_idle();
        addr(1'b0, 8'h1F, 8'hFE);
        dev(1'b0, 1'b1, 1'b1);
        rx(8'h11, 1'b0);
        // Interrupted read: nine released clocks then start and stop
        rx(8'h22, 1'b1);
        u_i2c_ctrl_model.start();
        u_i2c_ctrl_model.stop();
        dev(1'b0, 1'b1, 1'b1);
        rx(8'hC3, 1'b1);
        u_i2c_ctrl_model.stop();
    endtask
    task automatic t_strap();
        @(negedge mclk_i) straps = 3'h4;
        repeat (4) @(negedge mclk_i);
        dev(1'b0, 1'b0, 1'b0);
        check("standby", {7'h0, sb}, 8'h01);
        u_i2c_ctrl_model.stop();
        @(negedge mclk_i) straps = 3'h5;
        repeat (4) @(negedge mclk_i);
    endtask
    task automatic t_inhibit();
        @(negedge mclk_i) wp = 1'b1;
        repeat (4) @(negedge mclk_i);
        addr(1'b0, 8'h00, 8'h00);
        tx(8'h5A, 1'b1);
        u_i2c_ctrl_model.stop();
        check("busy", {7'h0, busy}, 8'h00);
        @(negedge mclk_i) wp = 1'b0;
        repeat (4) @(negedge mclk_i);
        addr(1'b0, 8'h00, 8'h00);
        dev(1'b0, 1'b1, 1'b1);
        rx(8'hC3, 1'b1);
        u_i2c_ctrl_model.stop();
    endtask
    task automatic t_id_area();
        addr(1'b1, 8'h00, 8'h03);
        tx(8'hA1, 1'b1);
        tx(8'hB2, 1'b1);
        u_i2c_ctrl_model.stop();
        wait_idle();
        addr(1'b1, 8'h04, 8'h00);
        tx(8'h02, 1'b1);
        u_i2c_ctrl_model.stop();
        wait_idle();
        addr(1'b1, 8'h00, 8'h03);
        tx(8'hFF, 1'b0);
        u_i2c_ctrl_model.stop();
        addr(1'b1, 8'h00, 8'h03);
        dev(1'b1, 1'b1, 1'b1);
        rx(8'hA1, 1'b0);
        rx(8'hB2, 1'b1);
        u_i2c_ctrl_model.stop();
        addr(1'b1, 8'h08, 8'h00);
        dev(1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 16; i++) begin
            rx(SN[127 - 8 * i -: 8], i == 15);
        end
        u_i2c_ctrl_model.stop();
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge mclk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        t_write_poll();
        t_page_read();
        t_strap();
        t_inhibit();
        t_id_area();
        tally_and_finish();
    end
    initial begin
        #500_000;
        err_total++;
        tally_and_finish();
    end
endmodule
